// ### dv/poweron_brownout_reset_bench.sv
// self-checking bench for the power-on and brown-out reset block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin \
	$display("Error %s expected %h seen %h", nm, ex, got); fail_count++; end end
module poweron_brownout_reset_bench
	import poweron_brownout_pkg::*;
;
	// =========================================
	// stimulus and bookkeeping
	logic       clk, rst_n, supplyOk, brownoutBelowLow, brownoutBelowHigh;
	logic       cfgBrownoutDetectOff, cfgBrownoutLevel, warmReset, wrStb, rdStb;
	logic [7:0] addr, wrData, rdData, fetchAddr, rv, pm;
	logic       cpuReset, fetchEnable, oscEnable, portForceQuasi, brownoutIrq, brownoutLevelSel;
	int         fail_count, samples_checked, cycles, n, i;
	integer     seed;

	poweron_brownout_reset i_poweron_brownout_reset (.clk(clk), .rst_n(rst_n),
		.supplyOk(supplyOk), .brownoutBelowLow(brownoutBelowLow),
		.brownoutBelowHigh(brownoutBelowHigh), .cfgBrownoutDetectOff(cfgBrownoutDetectOff),
		.cfgBrownoutLevel(cfgBrownoutLevel), .warmReset(warmReset), .addr(addr),
		.wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .cpuReset(cpuReset),
		.fetchEnable(fetchEnable), .fetchAddr(fetchAddr), .oscEnable(oscEnable),
		.portForceQuasi(portForceQuasi), .brownoutIrq(brownoutIrq),
		.brownoutLevelSel(brownoutLevelSel));

	always #12.5 clk = ~clk;

	// =========================================
	// bus tasks
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr   <= a;
		wrData <= d;
		wrStb  <= 1'b1;
		@(posedge clk);
		wrStb  <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		addr  <= a;
		rdStb <= 1'b1;
		@(posedge clk);
		rdStb <= 1'b0;
		#1 rv = rdData;
	endtask

	// the key pair must sit right before the protected write, nothing between
	task automatic unlockWr(input logic [7:0] d);
		wr(KEY_OFFSET, KEY_FIRST);
		wr(KEY_OFFSET, KEY_SECOND);
		wr(MONCTRL_OFFSET, d);
	endtask

	task automatic waitRelease();
		n = 0;
		while (cpuReset !== 1'b0 && n < 400)
		begin
			@(posedge clk);
			n++;
		end
		#1;
	endtask

	function automatic logic [7:0] pmVal(input logic on, input logic lv, input logic rs);
		return {on, lv, 1'b0, rs, 4'h0};
	endfunction

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// =========================================
	// hang guard: whole run needs well under a thousand cycles
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 4000)
		begin
			fail_count++;
			tally_and_finish();
		end
	end

	// =========================================
	// main sequence
	initial
	begin
		clk                  = 1'b0;
		rst_n                = 1'b0;
		supplyOk             = 1'b0;
		brownoutBelowLow     = 1'b0;
		brownoutBelowHigh    = 1'b0;
		cfgBrownoutDetectOff = 1'b0;
		cfgBrownoutLevel     = 1'b1;
		warmReset            = 1'b0;
		addr                 = 8'h00;
		wrData               = 8'h00;
		wrStb                = 1'b0;
		rdStb                = 1'b0;
		fail_count           = 0;
		samples_checked      = 0;
		cycles               = 0;
		seed                 = 32'h131d;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (10) @(posedge clk);
		#1 `CHK("hold", 1'b1, cpuReset)
		`CHK("fetch", 1'b0, fetchEnable)
		`CHK("oscOff", 1'b0, oscEnable)
		`CHK("quasi", 1'b1, portForceQuasi)
		@(posedge clk);
		supplyOk <= 1'b1;
		waitRelease();
		`CHK("startDelay", 1'b1, n >= OSC_START_CYCLES)
		`CHK("osc", 1'b1, oscEnable)
		`CHK("fetchRun", 1'b1, fetchEnable)
		`CHK("vector", RESET_VECTOR, fetchAddr)
		`CHK("quasiOff", 1'b0, portForceQuasi)
		rd(FLAGS_OFFSET);
		`CHK("cold", 1'b1, rv[COLDSTART_BIT])
		rd(MONCTRL_OFFSET);
		`CHK("detOn", 1'b1, rv[DETECT_ON_BIT])
		`CHK("lvlLoad", 1'b0, rv[LEVEL_SEL_BIT])
		`CHK("lvlSel", 1'b0, brownoutLevelSel)
		// clear the cold flag, then a warm reset with the other level configured
		wr(FLAGS_OFFSET, 8'h00);
		cfgBrownoutLevel <= 1'b0;
		@(posedge clk);
		warmReset <= 1'b1;
		@(posedge clk);
		warmReset <= 1'b0;
		repeat (3) @(posedge clk);
		waitRelease();
		rd(FLAGS_OFFSET);
		`CHK("warmCold", 1'b0, rv[COLDSTART_BIT])
		rd(MONCTRL_OFFSET);
		pm = rv;
		`CHK("lvlReload", 1'b1, rv[LEVEL_SEL_BIT])
		`CHK("lvlHigh", 1'b1, brownoutLevelSel)
		// any access between key and write spoils the unlock
		wr(KEY_OFFSET, KEY_FIRST);
		wr(KEY_OFFSET, KEY_SECOND);
		rd(FLAGS_OFFSET);
		wr(MONCTRL_OFFSET, 8'h00);
		rd(MONCTRL_OFFSET);
		`CHK("keyBroken", pm, rv)
		// random writes without the key are dropped; random unmapped reads give zero
		for (i = 0; i < 6; i++)
		begin
			wr(MONCTRL_OFFSET, 8'($random(seed)));
			rd(MONCTRL_OFFSET);
			`CHK("locked", pm, rv)
			rd(8'h10 + 8'($random(seed) & 8'h3f));
			`CHK("unmapped", 8'h00, rv)
		end
		// a value unlike the present one, so a dropped write would show
		unlockWr(pmVal(1'b1, 1'b0, 1'b1));
		rd(MONCTRL_OFFSET);
		`CHK("unlocked", pmVal(1'b1, 1'b0, 1'b1), rv)
		unlockWr(pmVal(1'b1, 1'b1, 1'b0));
		wr(IRQEN_OFFSET, 8'ha0);
		// low comparator alone must not count at the high level
		brownoutBelowLow <= 1'b1;
		repeat (6) @(posedge clk);
		rd(MONCTRL_OFFSET);
		`CHK("wrongLvl", 1'b0, rv[EVENT_FLAG_BIT])
		brownoutBelowHigh <= 1'b1;
		repeat (6) @(posedge clk);
		rd(MONCTRL_OFFSET);
		`CHK("fall", 1'b1, rv[EVENT_FLAG_BIT])
		`CHK("noReset", 1'b0, cpuReset)
		`CHK("irq", 1'b1, brownoutIrq)
		wr(IRQEN_OFFSET, 8'h20);
		// the request is registered, so it drops one edge after the enable
		@(posedge clk);
		#1 `CHK("irqMask", 1'b0, brownoutIrq)
		unlockWr(pmVal(1'b1, 1'b1, 1'b0));
		repeat (6) @(posedge clk);
		rd(MONCTRL_OFFSET);
		`CHK("stayClear", 1'b0, rv[EVENT_FLAG_BIT])
		brownoutBelowLow <= 1'b0;
		brownoutBelowHigh <= 1'b0;
		repeat (6) @(posedge clk);
		rd(MONCTRL_OFFSET);
		`CHK("rise", 1'b1, rv[EVENT_FLAG_BIT])
		// detector switched off: a crossing leaves no trace
		unlockWr(pmVal(1'b0, 1'b1, 1'b1));
		brownoutBelowHigh <= 1'b1;
		repeat (8) @(posedge clk);
		rd(MONCTRL_OFFSET);
		`CHK("offFlag", 1'b0, rv[EVENT_FLAG_BIT])
		`CHK("offReset", 1'b0, cpuReset)
		brownoutBelowHigh <= 1'b0;
		repeat (6) @(posedge clk);
		// detector on with reset enabled: a crossing resets the processor
		unlockWr(pmVal(1'b1, 1'b1, 1'b1));
		brownoutBelowHigh <= 1'b1;
		n = 0;
		while (cpuReset !== 1'b1 && n < 8)
		begin
			@(posedge clk);
			n++;
		end
		#1 `CHK("borReset", 1'b1, cpuReset)
		@(posedge clk);
		brownoutBelowHigh <= 1'b0;
		repeat (BOR_HOLD_CYCLES + 4) @(posedge clk);
		waitRelease();
		`CHK("borRelease", 1'b0, cpuReset)
		tally_and_finish();
	end
endmodule

// ### include/poweron_brownout_pkg.sv
// package: register map, field positions, reset values and timing for the reset block
package poweron_brownout_pkg;
	// =========================================
	// register offsets
	localparam logic [7:0] FLAGS_OFFSET    = 8'h87;
	localparam logic [7:0] MONCTRL_OFFSET  = 8'ha3;
	localparam logic [7:0] KEY_OFFSET      = 8'hc7;
	localparam logic [7:0] IRQEN_OFFSET    = 8'ha8;
	// =========================================
	// field positions
	localparam int COLDSTART_BIT  = 4;
	localparam int DETECT_ON_BIT  = 7;
	localparam int LEVEL_SEL_BIT  = 6;
	localparam int RESET_ON_BIT   = 4;
	localparam int EVENT_FLAG_BIT = 3;
	localparam int SUPPLY_IRQ_BIT = 5;
	localparam int GLOBAL_IRQ_BIT = 7;
	// =========================================
	// unlock key sequence
	localparam logic [7:0] KEY_FIRST  = 8'haa;
	localparam logic [7:0] KEY_SECOND = 8'h55;
	// =========================================
	// reset values and timing
	localparam logic [7:0] RESET_VECTOR      = 8'h00;
	localparam logic [7:0] FLAGS_WRITE_MASK  = 8'hdf;
	localparam int         CLK_MHZ           = 40;
	localparam int         OSC_START_NS      = 1000;
	localparam int         OSC_START_CYCLES  = (OSC_START_NS * CLK_MHZ + 999) / 1000;
	localparam int         BOR_HOLD_NS       = 200;
	localparam int         BOR_HOLD_CYCLES   = (BOR_HOLD_NS * CLK_MHZ + 999) / 1000;
	localparam int         CNT_W             = 8;
	// =========================================
	// sequencer states
	typedef enum logic [3:0]
	{
		ST_POR  = 4'b0001,
		ST_OSC  = 4'b0010,
		ST_RUN  = 4'b0100,
		ST_BOR  = 4'b1000
	} seq_state_t;
endpackage

// ### rtl/poweron_brownout_reset.sv
// power-on and brown-out reset sequencer with its flag, monitor control, interrupt enable and key registers
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
// Contract
// [RL1] hold processor in reset while supply low
// [RL2] start oscillator, then release at vector zero
// [RL3] power-on completion sets cold-start flag
// [RL4] other resets leave cold-start flag alone
// [RL5] software clears cold-start flag after start-up
// [RL6] force port pins quasi-bidirectional during reset
// [RL7] detect falling and rising threshold crossings
// [RL8] brown-out resets only with reset enable set
// [RL9] reset enable clear means flag instead
// [RL10] level select loaded from configuration at reset
// [RL11] select zero is low level, one high
// [RL12] crossing sets brown-out event flag
// [RL13] interrupt when flag and both enables set
// [RL14] software clears the event flag itself
// [RL15] control writes need unlock right before
// [RL16] detector enable loads inverted configuration bit
// [RL17] cleared flag stays clear until supply recovers
// [RL18] unlock is key first then second key
// [RL19] detector off means no brown-out effects
// [RL20] comparator outputs synchronised before use
module poweron_brownout_reset
	import poweron_brownout_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       supplyOk,
	input  wire logic       brownoutBelowLow,
	input  wire logic       brownoutBelowHigh,
	input  wire logic       cfgBrownoutDetectOff,
	input  wire logic       cfgBrownoutLevel,
	input  wire logic       warmReset,
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wrData,
	input  wire logic       wrStb,
	input  wire logic       rdStb,
	output logic      [7:0] rdData,
	output logic            cpuReset,
	output logic            fetchEnable,
	output logic      [7:0] fetchAddr,
	output logic            oscEnable,
	output logic            portForceQuasi,
	output logic            brownoutIrq,
	output logic            brownoutLevelSel
);
	// =========================================
	// synchronisers
	logic [2:0] syncA_q;
	logic [2:0] syncB_q;
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			syncA_q <= 3'h0;
			syncB_q <= 3'h0;
		end
		else
		begin
			syncA_q <= {brownoutBelowHigh, brownoutBelowLow, supplyOk}; // [RL20]
			syncB_q <= syncA_q;
		end
	end
	logic supplyGood;
	assign supplyGood = syncB_q[0];
	// =========================================
	// sequencer
	seq_state_t       state_q;
	logic [CNT_W-1:0] cnt_q;
	logic             detectOn_q;
	logic             levelSel_q;
	logic             resetOn_q;
	logic             eventFlag_q;
	logic             below_q;
	logic             belowNow;
	logic             crossing;
	logic             borFire;
	logic             inReset;
	assign belowNow = levelSel_q ? syncB_q[2] : syncB_q[1]; // [RL11]
	assign crossing = detectOn_q && (state_q == ST_RUN) && (belowNow != below_q); // [RL7] [RL19]
	assign borFire  = crossing && resetOn_q; // [RL8] [RL9]
	assign inReset  = (state_q != ST_RUN);
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q <= ST_POR;
			cnt_q   <= '0;
		end
		else
		begin
			case (state_q)
				ST_POR:
				begin
					cnt_q <= '0;
					if (supplyGood)
						state_q <= ST_OSC; // [RL1]
				end
				ST_OSC:
				begin
					if (!supplyGood)
						state_q <= ST_POR;
					else if (cnt_q == CNT_W'(OSC_START_CYCLES - 1))
						state_q <= ST_RUN; // [RL2]
					else
						cnt_q <= cnt_q + 1'b1;
				end
				ST_RUN:
				begin
					cnt_q <= '0;
					if (!supplyGood)
						state_q <= ST_POR;
					else if (borFire || warmReset)
						state_q <= ST_BOR;
				end
				ST_BOR:
				begin
					if (!supplyGood)
						state_q <= ST_POR;
					else if (cnt_q == CNT_W'(BOR_HOLD_CYCLES - 1))
						state_q <= ST_RUN;
					else
						cnt_q <= cnt_q + 1'b1;
				end
				default:
					state_q <= ST_POR;
			endcase
		end
	end
	// =========================================
	// outputs of the sequencer
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cpuReset       <= 1'b1;
			fetchEnable    <= 1'b0;
			fetchAddr      <= RESET_VECTOR;
			oscEnable      <= 1'b0;
			portForceQuasi <= 1'b1;
		end
		else
		begin
			cpuReset       <= inReset; // [RL1]
			fetchEnable    <= !inReset; // [RL1] [RL2]
			fetchAddr      <= RESET_VECTOR; // [RL2]
			oscEnable      <= (state_q != ST_POR); // [RL2]
			portForceQuasi <= inReset; // [RL6]
		end
	end
	// =========================================
	// timed-access unlock
	logic keyArmed_q;
	logic unlocked_q;
	logic keyWr;
	assign keyWr = wrStb && (addr == KEY_OFFSET);
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			keyArmed_q <= 1'b0;
			unlocked_q <= 1'b0;
		end
		else if (wrStb || rdStb)
		begin
			keyArmed_q <= keyWr && (wrData == KEY_FIRST); // [RL18]
			unlocked_q <= keyWr && (wrData == KEY_SECOND) && keyArmed_q; // [RL15]
		end
	end
	logic monCtrlWr;
	assign monCtrlWr = wrStb && (addr == MONCTRL_OFFSET) && unlocked_q; // [RL15]
	// =========================================
	// monitor control register
	logic loadCfg;
	assign loadCfg = (state_q == ST_POR) || (state_q == ST_BOR);
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			detectOn_q <= 1'b0;
			levelSel_q <= 1'b0;
			resetOn_q  <= 1'b0;
		end
		else if (loadCfg)
		begin
			detectOn_q <= !cfgBrownoutDetectOff; // [RL16]
			levelSel_q <= !cfgBrownoutLevel; // [RL10] [RL11]
		end
		else if (monCtrlWr)
		begin
			detectOn_q <= wrData[DETECT_ON_BIT];
			levelSel_q <= wrData[LEVEL_SEL_BIT];
			resetOn_q  <= wrData[RESET_ON_BIT];
		end
	end
	// level tracked so a cleared flag waits for the opposite crossing
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			below_q <= 1'b0;
		else if (state_q != ST_RUN)
			below_q <= 1'b0;
		else
			below_q <= belowNow; // [RL17]
	end
	// set wins over a software clear in the same cycle
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			eventFlag_q <= 1'b0;
		else if (crossing && !resetOn_q)
			eventFlag_q <= 1'b1; // [RL12] [RL9]
		else if (monCtrlWr)
			eventFlag_q <= wrData[EVENT_FLAG_BIT]; // [RL14]
	end
	// =========================================
	// cold-start flag and interrupt enables
	logic coldstart_q;
	logic [1:0] irqEn_q;
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			coldstart_q <= 1'b0;
		else if (state_q == ST_OSC && cnt_q == CNT_W'(OSC_START_CYCLES - 1) && supplyGood)
			coldstart_q <= 1'b1; // [RL3]
		else if (wrStb && addr == FLAGS_OFFSET)
			coldstart_q <= wrData[COLDSTART_BIT]; // [RL4] [RL5]
	end
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			irqEn_q <= 2'h0;
		else if (loadCfg)
			irqEn_q <= 2'h0;
		else if (wrStb && addr == IRQEN_OFFSET)
			irqEn_q <= {wrData[GLOBAL_IRQ_BIT], wrData[SUPPLY_IRQ_BIT]};
	end
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			brownoutIrq      <= 1'b0;
			brownoutLevelSel <= 1'b0;
		end
		else
		begin
			brownoutIrq      <= eventFlag_q && irqEn_q[0] && irqEn_q[1] && detectOn_q; // [RL13]
			brownoutLevelSel <= levelSel_q;
		end
	end
	// =========================================
	// read port
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			rdData <= 8'h00;
		else if (rdStb)
		begin
			case (addr)
				FLAGS_OFFSET: rdData <= 8'(coldstart_q) << COLDSTART_BIT;
				MONCTRL_OFFSET: rdData <= (8'(detectOn_q) << DETECT_ON_BIT)
					| (8'(levelSel_q) << LEVEL_SEL_BIT)
					| (8'(resetOn_q) << RESET_ON_BIT)
					| (8'(eventFlag_q) << EVENT_FLAG_BIT);
				IRQEN_OFFSET: rdData <= (8'(irqEn_q[1]) << GLOBAL_IRQ_BIT)
					| (8'(irqEn_q[0]) << SUPPLY_IRQ_BIT);
				default:      rdData <= 8'h00;
			endcase
		end
		else
			rdData <= 8'h00;
	end
	// =========================================
	// checks
	AST_HOLD_LOW: assert property (@(posedge clk) disable iff (!rst_n) // [RL1]
		!supplyGood |-> ##2 (!fetchEnable && cpuReset))
		else $error("fetch enabled while supply low");
	AST_RELEASE: assert property (@(posedge clk) disable iff (!rst_n) // [RL2]
		$rose(fetchEnable) |-> fetchAddr == RESET_VECTOR && $past(oscEnable))
		else $error("release without oscillator or wrong vector");
	AST_COLD_SET: assert property (@(posedge clk) disable iff (!rst_n) // [RL3]
		(state_q == ST_RUN && $past(state_q) == ST_OSC) |-> coldstart_q)
		else $error("cold-start flag not set after power-on");
	AST_COLD_KEEP: assert property (@(posedge clk) disable iff (!rst_n) // [RL4]
		(state_q == ST_BOR && !(wrStb && addr == FLAGS_OFFSET)) |=> $stable(coldstart_q))
		else $error("cold-start flag changed by warm reset");
	AST_QUASI: assert property (@(posedge clk) disable iff (!rst_n) // [RL6]
		inReset |=> (portForceQuasi && cpuReset))
		else $error("port not forced during reset");
	AST_BOR: assert property (@(posedge clk) disable iff (!rst_n) // [RL8]
		(borFire && supplyGood) |=> state_q == ST_BOR)
		else $error("brown-out reset missed");
	AST_FLAG: assert property (@(posedge clk) disable iff (!rst_n) // [RL12]
		(crossing && !resetOn_q) |=> eventFlag_q)
		else $error("event flag not set");
	AST_IRQ: assert property (@(posedge clk) disable iff (!rst_n) // [RL13]
		(eventFlag_q && irqEn_q == 2'h3 && detectOn_q) |=> brownoutIrq)
		else $error("interrupt not raised");
	AST_LOCK: assert property (@(posedge clk) disable iff (!rst_n) // [RL15]
		(wrStb && addr == MONCTRL_OFFSET && !unlocked_q && !loadCfg && !crossing)
		|=> $stable(resetOn_q) && $stable(eventFlag_q))
		else $error("locked write took effect");
	AST_DETECT_OFF: assert property (@(posedge clk) disable iff (!rst_n) // [RL19]
		(!detectOn_q && !monCtrlWr) |=> $stable(eventFlag_q))
		else $error("event with detector off");
	COV_POR: cover property (@(posedge clk) disable iff (!rst_n) $rose(fetchEnable));
	COV_BOR: cover property (@(posedge clk) disable iff (!rst_n) borFire);
	COV_FLAG: cover property (@(posedge clk) disable iff (!rst_n) $rose(eventFlag_q));
	COV_UNLOCK: cover property (@(posedge clk) disable iff (!rst_n) monCtrlWr);
endmodule
